//--- rtl/pmc_pkg.sv
// shared constants, modes and carrier types of the power mode clock controller
package pmc_pkg;

    // operating modes, held in the mode state register
    typedef enum logic [2:0] {
        PMC_FULLON = 3'h0,
        PMC_ACTIVE = 3'h1,
        PMC_SLEEP = 3'h2,
        PMC_DEEPSLEEP = 3'h3,
        PMC_HIBERNATE = 3'h4
    } pmc_mode_t;

    // apb request from the master, bundled
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pmc_apb_req_t;

    // register byte offsets
    localparam logic [7:0] PMC_PLL_CONTROL_OFS = 8'h00;
    localparam logic [7:0] PMC_DIVIDER_OFS = 8'h04;
    localparam logic [7:0] PMC_REGULATOR_OFS = 8'h08;
    localparam logic [7:0] PMC_SDRAM_GCTL_OFS = 8'h0c;
    localparam logic [7:0] PMC_ASYNC_GCTL_OFS = 8'h10;
    localparam logic [7:0] PMC_MODE_REQ_OFS = 8'h14;
    localparam logic [7:0] PMC_STATUS_OFS = 8'h18;

    // pll control fields
    localparam int PMC_MSEL_LSB = 0;
    localparam int PMC_MSEL_W = 6;
    localparam int PMC_HALVE_BIT = 6;
    localparam int PMC_BYPASS_BIT = 8;
    localparam int PMC_PLLOFF_BIT = 9;
    localparam logic [5:0] PMC_MSEL_RESET = 6'h0a;

    // divider fields
    localparam int PMC_SSEL_LSB = 0;
    localparam int PMC_SSEL_W = 4;
    localparam int PMC_CSEL_LSB = 4;
    localparam int PMC_CSEL_W = 2;
    localparam logic [3:0] PMC_SSEL_RESET = 4'h4;
    localparam logic [1:0] PMC_CSEL_RESET = 2'h0;

    // single enable bit of regulator, sdram and async memory registers
    localparam int PMC_ENABLE_BIT = 0;

    // mode request and status fields
    localparam int PMC_MODE_LSB = 0;
    localparam int PMC_MODE_W = 3;
    localparam int PMC_PENDING_BIT = 4;
    localparam int PMC_APPLIED_LSB = 8;
    localparam int PMC_APPLIED_HALVE_BIT = 14;
    localparam int PMC_PLLON_BIT = 16;

    // clock generator counter width and fixed half period
    localparam int PMC_DIV_W = 5;
    localparam logic [4:0] PMC_HALF_ONE = 5'h01;

endpackage

//--- rtl/pmc_clock_gen.sv
// glitch-free programmable clock generator, one per generated clock
`timescale 1ns/1ps
module pmc_clock_gen
    import pmc_pkg::*;
#(
    parameter int W = PMC_DIV_W
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] halfPeriod,
    output logic system_clock_out
);

    logic [W-1:0] count;
    logic [W-1:0] latched;

    // ratio is taken only at a period start, so a high phase is never cut short
    always_ff @(posedge mclk) begin
        if (reset) begin
            system_clock_out <= 1'b0;
            count <= '0;
            latched <= W'(1);
        end else if (tick) begin
            if ((count + W'(1)) >= latched) begin
                count <= '0;
                if (system_clock_out) begin
                    system_clock_out <= 1'b0;
                end else begin
                    latched <= (halfPeriod == '0) ? W'(1) : halfPeriod;
                    system_clock_out <= run; // stop only while low
                end
            end else begin
                count <= count + W'(1);
            end
        end
    end

endmodule

//--- rtl/pmc_power_ctrl.sv
// power mode sequencer, clock generation and apb register file
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
module pmc_power_ctrl
    import pmc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire pmc_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic inputClock,
    input wire logic wakeup,
    input wire logic rtcIrq,
    input wire logic resetPin,
    output logic coreClock,
    output logic sysClock,
    output logic systemClockOut,
    output logic bufferedClockOut,
    output logic pllEnabled,
    output logic pllBypassed,
    output logic coreSupplyOn,
    output logic bootStart,
    output logic dmaL1Allow,
    output logic asyncAccessAllow,
    output pmc_mode_t mode
);

    localparam int PIN_N = 4;
    localparam int PIN_WAKE = 0;
    localparam int PIN_RTC = 1;
    localparam int PIN_RST = 2;
    localparam int PIN_CLK = 3;

    logic [PIN_N-1:0][2:0] pinSync;
    logic [PIN_N-1:0] pinLevel;
    logic clkLevelDly;
    logic inputEdge;
    logic [PMC_MSEL_W-1:0] msel;
    logic halve;
    logic bypass;
    logic pllOff;
    logic [PMC_MSEL_W-1:0] appliedMsel;
    logic appliedHalve;
    logic [PMC_SSEL_W-1:0] ssel;
    logic [PMC_CSEL_W-1:0] csel;
    logic clkbufEn;
    logic sdramClkEn;
    logic asyncClkEn;
    pmc_mode_t modeReq;
    logic reqPending;
    logic reqTaken;
    pmc_mode_t next_mode;
    logic apbWrite;
    logic apbSetup;
    logic coreRun;
    logic sysRun;
    logic clkTick;
    logic [PMC_DIV_W-1:0] coreHalf;
    logic [PMC_DIV_W-1:0] sysHalf;

    // decode of a byte offset into a known register
    function automatic logic isMapped(input logic [7:0] addr);
        case (addr)
            PMC_PLL_CONTROL_OFS, PMC_DIVIDER_OFS, PMC_REGULATOR_OFS, PMC_SDRAM_GCTL_OFS,
            PMC_ASYNC_GCTL_OFS, PMC_MODE_REQ_OFS, PMC_STATUS_OFS: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three flops, a change counts once stages two and three agree
    always_ff @(posedge mclk) begin
        if (reset) begin
            pinSync <= '0;
            pinLevel <= '0;
        end else begin
            for (int i = 0; i < PIN_N; i++) begin
                pinSync[i] <= {pinSync[i][1:0], 1'b0};
                if (pinSync[i][2] == pinSync[i][1]) begin
                    pinLevel[i] <= pinSync[i][2];
                end
            end
            pinSync[PIN_WAKE][0] <= wakeup;
            pinSync[PIN_RTC][0] <= rtcIrq;
            pinSync[PIN_RST][0] <= resetPin;
            pinSync[PIN_CLK][0] <= inputClock;
        end
    end

    // edge of the filtered input clock paces the clocks in bypass
    always_ff @(posedge mclk) begin
        if (reset) begin
            clkLevelDly <= 1'b0;
        end else begin
            clkLevelDly <= pinLevel[PIN_CLK];
        end
    end
    assign inputEdge = pinLevel[PIN_CLK] ^ clkLevelDly;

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave: pready rises the cycle after setup, so no wait states
    assign apbSetup = apbReq.psel && !apbReq.penable;
    assign apbWrite = apbReq.psel && apbReq.penable && pready && apbReq.pwrite;

    always_ff @(posedge mclk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apbSetup;
            pslverr <= apbSetup && !isMapped(apbReq.paddr);
            if (apbSetup && !apbReq.pwrite) begin
                prdata <= '0;
                case (apbReq.paddr)
                    PMC_PLL_CONTROL_OFS: begin
                        prdata[PMC_MSEL_LSB +: PMC_MSEL_W] <= msel;
                        prdata[PMC_HALVE_BIT] <= halve;
                        prdata[PMC_BYPASS_BIT] <= bypass;
                        prdata[PMC_PLLOFF_BIT] <= pllOff;
                    end
                    PMC_DIVIDER_OFS: begin
                        prdata[PMC_SSEL_LSB +: PMC_SSEL_W] <= ssel;
                        prdata[PMC_CSEL_LSB +: PMC_CSEL_W] <= csel;
                    end
                    PMC_REGULATOR_OFS: prdata[PMC_ENABLE_BIT] <= clkbufEn;
                    PMC_SDRAM_GCTL_OFS: prdata[PMC_ENABLE_BIT] <= sdramClkEn;
                    PMC_ASYNC_GCTL_OFS: prdata[PMC_ENABLE_BIT] <= asyncClkEn;
                    PMC_MODE_REQ_OFS: begin
                        prdata[PMC_MODE_LSB +: PMC_MODE_W] <= modeReq;
                        prdata[PMC_PENDING_BIT] <= reqPending;
                    end
                    PMC_STATUS_OFS: begin
                        prdata[PMC_MODE_LSB +: PMC_MODE_W] <= mode;
                        prdata[PMC_APPLIED_LSB +: PMC_MSEL_W] <= appliedMsel;
                        prdata[PMC_APPLIED_HALVE_BIT] <= appliedHalve;
                        prdata[PMC_PLLON_BIT] <= pllEnabled;
                    end
                    default: prdata <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pll control register; multiplier is only stored here, applied at full-on entry
    always_ff @(posedge mclk) begin
        if (reset) begin
            msel <= PMC_MSEL_RESET;
            halve <= 1'b0;
            bypass <= 1'b0;
            pllOff <= 1'b0;
        end else if (apbWrite && apbReq.paddr == PMC_PLL_CONTROL_OFS) begin
            msel <= apbReq.pwdata[PMC_MSEL_LSB +: PMC_MSEL_W];
            halve <= apbReq.pwdata[PMC_HALVE_BIT];
            bypass <= apbReq.pwdata[PMC_BYPASS_BIT];
            pllOff <= apbReq.pwdata[PMC_PLLOFF_BIT];
        end
    end

    // divider register, feeds the generators directly with no relock
    always_ff @(posedge mclk) begin
        if (reset) begin
            ssel <= PMC_SSEL_RESET;
            csel <= PMC_CSEL_RESET;
        end else if (apbWrite && apbReq.paddr == PMC_DIVIDER_OFS) begin
            ssel <= apbReq.pwdata[PMC_SSEL_LSB +: PMC_SSEL_W];
            csel <= apbReq.pwdata[PMC_CSEL_LSB +: PMC_CSEL_W];
        end
    end

    // output enables, all on after reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            clkbufEn <= 1'b1;
            sdramClkEn <= 1'b1;
            asyncClkEn <= 1'b1;
        end else if (apbWrite) begin
            if (apbReq.paddr == PMC_REGULATOR_OFS) begin
                clkbufEn <= apbReq.pwdata[PMC_ENABLE_BIT];
            end
            if (apbReq.paddr == PMC_SDRAM_GCTL_OFS) begin
                sdramClkEn <= apbReq.pwdata[PMC_ENABLE_BIT];
            end
            if (apbReq.paddr == PMC_ASYNC_GCTL_OFS) begin
                asyncClkEn <= apbReq.pwdata[PMC_ENABLE_BIT];
            end
        end
    end

    // mode request; a new write wins over the clear by the sequencer
    always_ff @(posedge mclk) begin
        if (reset) begin
            modeReq <= PMC_FULLON;
            reqPending <= 1'b0;
        end else if (apbWrite && apbReq.paddr == PMC_MODE_REQ_OFS) begin
            modeReq <= pmc_mode_t'(apbReq.pwdata[PMC_MODE_LSB +: PMC_MODE_W]);
            reqPending <= 1'b1;
        end else if (reqTaken) begin
            reqPending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode sequencer; requests only count while software runs
    always_comb begin
        next_mode = mode;
        reqTaken = 1'b0;
        case (mode)
            PMC_FULLON, PMC_ACTIVE: begin
                if (reqPending) begin
                    if (mode == PMC_ACTIVE && pllOff &&
                        (modeReq == PMC_FULLON || modeReq == PMC_SLEEP)) begin
                        reqTaken = 1'b0;
                    end else if (modeReq == PMC_FULLON || modeReq == PMC_ACTIVE ||
                                 modeReq == PMC_SLEEP || modeReq == PMC_DEEPSLEEP ||
                                 modeReq == PMC_HIBERNATE) begin
                        next_mode = modeReq;
                        reqTaken = 1'b1;
                    end else begin
                        reqTaken = 1'b1; // unknown code dropped
                    end
                end
            end
            PMC_SLEEP: begin
                if (pinLevel[PIN_WAKE]) begin
                    next_mode = bypass ? PMC_ACTIVE : PMC_FULLON;
                end
            end
            PMC_DEEPSLEEP: begin
                if (pinLevel[PIN_RST]) begin
                    next_mode = PMC_FULLON;
                end else if (pinLevel[PIN_RTC]) begin
                    next_mode = PMC_ACTIVE;
                end
            end
            PMC_HIBERNATE: begin
                if (pinLevel[PIN_RST]) begin
                    next_mode = PMC_FULLON;
                end
            end
            default: next_mode = PMC_FULLON;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mode <= PMC_FULLON;
        end else begin
            mode <= next_mode;
        end
    end

    // multiplier taken over only on the way into full-on
    always_ff @(posedge mclk) begin
        if (reset) begin
            appliedMsel <= PMC_MSEL_RESET;
            appliedHalve <= 1'b0;
        end else if (next_mode == PMC_FULLON && mode != PMC_FULLON) begin
            appliedMsel <= msel;
            appliedHalve <= halve;
        end
    end

    // mode-derived controls, registered from the next mode to stay aligned with it
    always_ff @(posedge mclk) begin
        if (reset) begin
            pllEnabled <= 1'b1;
            pllBypassed <= 1'b0;
            coreSupplyOn <= 1'b1;
            bootStart <= 1'b0;
            dmaL1Allow <= 1'b1;
            asyncAccessAllow <= 1'b1;
        end else begin
            pllEnabled <= (next_mode == PMC_FULLON) || (next_mode == PMC_SLEEP) ||
                          (next_mode == PMC_ACTIVE && !pllOff);
            pllBypassed <= (next_mode == PMC_ACTIVE);
            coreSupplyOn <= (next_mode != PMC_HIBERNATE);
            bootStart <= (mode == PMC_HIBERNATE) && (next_mode == PMC_FULLON);
            dmaL1Allow <= (next_mode == PMC_FULLON) || (next_mode == PMC_ACTIVE);
            asyncAccessAllow <= (next_mode != PMC_DEEPSLEEP) && (next_mode != PMC_HIBERNATE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock generation: mclk stands in for the vco; in bypass each input edge is one tick
    assign coreRun = (mode == PMC_FULLON) || (mode == PMC_ACTIVE);
    assign sysRun = coreRun || (mode == PMC_SLEEP);
    assign clkTick = (mode == PMC_ACTIVE) ? inputEdge : 1'b1;
    assign coreHalf = (mode == PMC_ACTIVE) ? PMC_HALF_ONE : (PMC_HALF_ONE << csel);
    assign sysHalf = (mode == PMC_ACTIVE) ? PMC_HALF_ONE : PMC_DIV_W'(ssel);

    pmc_clock_gen #(.W(PMC_DIV_W)) coreGen (
        .mclk(mclk),
        .reset(reset),
        .run(coreRun),
        .tick(clkTick),
        .halfPeriod(coreHalf),
        .system_clock_out(coreClock)
    );

    pmc_clock_gen #(.W(PMC_DIV_W)) sysGen (
        .mclk(mclk),
        .reset(reset),
        .run(sysRun),
        .tick(clkTick),
        .halfPeriod(sysHalf),
        .system_clock_out(sysClock)
    );

    // pin copies; one flop of delay is the price of a clean registered output
    always_ff @(posedge mclk) begin
        if (reset) begin
            systemClockOut <= 1'b0;
            bufferedClockOut <= 1'b0;
        end else begin
            systemClockOut <= sysClock && sdramClkEn && asyncClkEn;
            bufferedClockOut <= pinLevel[PIN_CLK] && clkbufEn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks on the sequencer and the outputs
    property p_pll_reenable;
        @(posedge mclk) disable iff (reset)
        (mode == PMC_ACTIVE && pllOff) |=> (mode != PMC_FULLON && mode != PMC_SLEEP);
    endproperty
    a_pll_reenable: assert property (p_pll_reenable) else $error("left active with pll off");

    property p_sleep_core_stop;
        @(posedge mclk) disable iff (reset)
        (mode == PMC_SLEEP && $past(mode) == PMC_SLEEP && !coreClock) |=> !coreClock;
    endproperty
    a_sleep_core_stop: assert property (p_sleep_core_stop) else $error("core clock ran in sleep");

    property p_sleep_pll_on;
        @(posedge mclk) disable iff (reset)
        (mode == PMC_SLEEP) |-> (pllEnabled && !dmaL1Allow);
    endproperty
    a_sleep_pll_on: assert property (p_sleep_pll_on) else $error("sleep pll or dma wrong");

    property p_wake_select;
        @(posedge mclk) disable iff (reset)
        (mode == PMC_SLEEP && pinLevel[PIN_WAKE]) |=>
            (mode == ($past(bypass) ? PMC_ACTIVE : PMC_FULLON));
    endproperty
    a_wake_select: assert property (p_wake_select) else $error("wrong mode after wake");

    property p_deep_off;
        @(posedge mclk) disable iff (reset)
        (mode == PMC_DEEPSLEEP) |-> (!pllEnabled && !asyncAccessAllow && !dmaL1Allow);
    endproperty
    a_deep_off: assert property (p_deep_off) else $error("deep sleep resources active");

    property p_deep_hold;
        @(posedge mclk) disable iff (reset)
        (mode == PMC_DEEPSLEEP && !pinLevel[PIN_RST] && !pinLevel[PIN_RTC]) |=> (mode == PMC_DEEPSLEEP);
    endproperty
    a_deep_hold: assert property (p_deep_hold) else $error("deep sleep left without cause");

    property p_deep_rtc;
        @(posedge mclk) disable iff (reset)
        (mode == PMC_DEEPSLEEP && pinLevel[PIN_RTC] && !pinLevel[PIN_RST]) |=> (mode == PMC_ACTIVE);
    endproperty
    a_deep_rtc: assert property (p_deep_rtc) else $error("rtc did not give active");

    property p_deep_reset;
        @(posedge mclk) disable iff (reset)
        (mode == PMC_DEEPSLEEP && pinLevel[PIN_RST]) |=> (mode == PMC_FULLON);
    endproperty
    a_deep_reset: assert property (p_deep_reset) else $error("reset did not give full-on");

    property p_hib_boot;
        @(posedge mclk) disable iff (reset)
        (mode == PMC_HIBERNATE && pinLevel[PIN_RST]) |=> (bootStart && coreSupplyOn) ##1 !bootStart;
    endproperty
    a_hib_boot: assert property (p_hib_boot) else $error("no boot after hibernate");

    property p_buffered_clock_out_off;
        @(posedge mclk) disable iff (reset)
        !clkbufEn |=> !bufferedClockOut;
    endproperty
    a_buffered_clock_out_off: assert property (p_buffered_clock_out_off) else $error("buffered clock not gated");

    property p_fullon_pll;
        @(posedge mclk) disable iff (reset)
        (mode == PMC_FULLON) |-> (pllEnabled && !pllBypassed);
    endproperty
    a_fullon_pll: assert property (p_fullon_pll) else $error("full-on pll state wrong");

    property p_mult_apply;
        @(posedge mclk) disable iff (reset)
        (mode != PMC_FULLON) ##1 (mode == PMC_FULLON) |-> (appliedMsel == $past(msel));
    endproperty
    a_mult_apply: assert property (p_mult_apply) else $error("multiplier not applied");

endmodule

//--- sim/pmc_far_side.sv
// far side model: free-running input clock and stretched wake, rtc and reset pins
`timescale 1ns/1ps
module pmc_far_side (
    input wire logic mclk,
    input wire logic [2:0] evt,
    output logic inputClock,
    output logic wakeup,
    output logic rtcIrq,
    output logic resetPin
);
    logic [3:0] hold [3] = '{4'h0, 4'h0, 4'h0}; // pins idle low from time zero, never unknown

    // oscillator never halts, phase unrelated to mclk
    initial begin
        inputClock = 1'b0;
        forever #137 inputClock = ~inputClock;
    end

    // each event pin held 8 cycles so the synchroniser surely sees it
    always @(posedge mclk) begin
        for (int i = 0; i < 3; i++) begin
            hold[i] <= evt[i] ? 4'h8 : (hold[i] != 4'h0 ? hold[i] - 4'h1 : 4'h0);
        end
    end
    assign wakeup = hold[0] != 4'h0;
    assign rtcIrq = hold[1] != 4'h0;
    assign resetPin = hold[2] != 4'h0;
endmodule

//--- sim/testbench.sv
// self-checking bench for the power mode clock controller
`timescale 1ns/1ps
module testbench;
    import pmc_pkg::*;
    logic mclk, reset, pready, pslverr, rerr, inputClock, wakeup, rtcIrq, resetPin;
    logic coreClock, sysClock, systemClockOut, bufferedClockOut, pllEnabled, pllBypassed;
    logic coreSupplyOn, bootStart, dmaL1Allow, asyncAccessAllow;
    logic [31:0] prdata, rd;
    logic [3:0] pv, cv, ssel;
    logic [1:0] csel;
    logic [5:0] msel;
    logic [2:0] evt;
    pmc_apb_req_t apbReq;
    pmc_mode_t mode;
    int fails, check_count, nc, ns, nb, no, boots;
    localparam int IN_HALF_NS = 137; // half period of the far side oscillator

    pmc_power_ctrl pmc_power_ctrl_inst (.mclk(mclk), .reset(reset), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .inputClock(inputClock), .wakeup(wakeup), .rtcIrq(rtcIrq),
        .resetPin(resetPin), .coreClock(coreClock), .sysClock(sysClock), .systemClockOut(systemClockOut),
        .bufferedClockOut(bufferedClockOut), .pllEnabled(pllEnabled), .pllBypassed(pllBypassed),
        .coreSupplyOn(coreSupplyOn), .bootStart(bootStart), .dmaL1Allow(dmaL1Allow),
        .asyncAccessAllow(asyncAccessAllow), .mode(mode));
    pmc_far_side pmc_far_side_inst (.mclk(mclk), .evt(evt), .inputClock(inputClock), .wakeup(wakeup),
        .rtcIrq(rtcIrq), .resetPin(resetPin));

    ////////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) if (bootStart === 1'b1) boots++;

    task finish_test;
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic ok);
        check_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t mismatch at check %0d", $time, check_count);
        end
    endtask

    // apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        // no local limit: only the watchdog ends a wait for pready
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        apbReq <= '0;
        @(posedge mclk);
    endtask

    task req(input logic [2:0] m);
        apb(1'b1, PMC_MODE_REQ_OFS, {29'h0, m});
    endtask

    task wait_mode(input pmc_mode_t m);
        int n;
        n = 0;
        while (mode !== m && n < 40) begin
            @(posedge mclk);
            n++;
        end
        chk(mode === m);
    endtask

    task fire(input int i);
        evt[i] <= 1'b1;
        @(posedge mclk);
        evt <= '0;
        @(posedge mclk);
    endtask

    // rising edges of core, system, buffered and external clocks
    task edges(input int cyc);
        nc = 0; ns = 0; nb = 0; no = 0;
        pv = {coreClock, sysClock, bufferedClockOut, systemClockOut}; // a stale level must not count as an edge
        repeat (cyc) begin
            @(posedge mclk);
            cv = {coreClock, sysClock, bufferedClockOut, systemClockOut};
            nc += int'(cv[3] & ~pv[3]);
            ns += int'(cv[2] & ~pv[2]);
            nb += int'(cv[1] & ~pv[1]);
            no += int'(cv[0] & ~pv[0]);
            pv = cv;
        end
    endtask

    function automatic int exp_edges(int span, int half);
        return span / (2 * half);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog far beyond the expected run length
    initial begin
        #(25 * 20000);
        fails++;
        finish_test;
    end

    initial begin
        apbReq = '0; evt = '0; reset = 1'b1; fails = 0; check_count = 0; boots = 0; pv = '0;
        void'($urandom(32'hea81d925));
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk(mode === PMC_FULLON && pllEnabled === 1'b1 && pllBypassed === 1'b0);
        apb(1'b0, PMC_PLL_CONTROL_OFS, 32'h0);
        chk(rd === 32'h0000000a);
        apb(1'b0, PMC_STATUS_OFS, 32'h0);
        chk(rd === 32'h00010a00);
        apb(1'b0, 8'h1c, 32'h0);
        chk(rerr === 1'b1 && rd === 32'h0);
        edges(40);
        chk(nb > 0 && no > 0);
        apb(1'b1, PMC_REGULATOR_OFS, 32'h0);
        apb(1'b1, PMC_SDRAM_GCTL_OFS, 32'h0);
        edges(40);
        chk(nb == 0 && no == 0);
        apb(1'b1, PMC_REGULATOR_OFS, 32'h1);
        apb(1'b1, PMC_SDRAM_GCTL_OFS, 32'h1);
        // divider: fastest, slowest and a random ratio, core ratio random too, no relock
        for (int i = 0; i < 3; i++) begin
            ssel = (i == 0) ? 4'h1 : (i == 1) ? 4'hf : 4'($urandom_range(14, 2));
            csel = 2'($urandom_range(3, 0));
            apb(1'b1, PMC_DIVIDER_OFS, {26'h0, csel, ssel});
            edges(40);
            edges(120);
            chk(ns >= exp_edges(120, ssel) && ns <= exp_edges(120, ssel) + 1);
            chk(nc >= exp_edges(120, 1 << csel) && nc <= exp_edges(120, 1 << csel) + 1);
        end
        req(PMC_ACTIVE);
        wait_mode(PMC_ACTIVE);
        chk(pllBypassed === 1'b1 && coreSupplyOn === 1'b1);
        edges(160); // the old ratio first finishes its period, now paced by input edges
        edges(110);
        chk(ns >= exp_edges(110 * 25, IN_HALF_NS) - 1 && ns <= exp_edges(110 * 25, IN_HALF_NS) + 1);
        chk(nc >= exp_edges(110 * 25, IN_HALF_NS) - 1 && nc <= exp_edges(110 * 25, IN_HALF_NS) + 1);
        msel = 6'($urandom_range(63, 11));
        apb(1'b1, PMC_PLL_CONTROL_OFS, {22'h0, 2'b10, 2'b00, msel});
        apb(1'b0, PMC_STATUS_OFS, 32'h0);
        chk(rd[13:8] === 6'h0a);
        req(PMC_FULLON);
        repeat (20) @(posedge mclk);
        chk(mode === PMC_ACTIVE);
        apb(1'b1, PMC_PLL_CONTROL_OFS, {26'h0, msel});
        wait_mode(PMC_FULLON);
        apb(1'b0, PMC_STATUS_OFS, 32'h0);
        chk(rd[13:8] === msel && rd[16] === 1'b1);
        req(PMC_SLEEP);
        wait_mode(PMC_SLEEP);
        edges(60);
        chk(nc == 0 && ns > 0 && pllEnabled === 1'b1);
        chk(dmaL1Allow === 1'b0);
        fire(0);
        wait_mode(PMC_FULLON);
        repeat (12) @(posedge mclk); // stretched wake pulse dies out before the next sleep
        apb(1'b1, PMC_PLL_CONTROL_OFS, {22'h0, 2'b01, 2'b00, msel});
        req(PMC_SLEEP);
        wait_mode(PMC_SLEEP);
        fire(0);
        wait_mode(PMC_ACTIVE);
        req(PMC_DEEPSLEEP);
        wait_mode(PMC_DEEPSLEEP);
        edges(60);
        chk(nc == 0 && ns == 0 && pllEnabled === 1'b0 && asyncAccessAllow === 1'b0);
        req(PMC_FULLON);
        fire(0);
        repeat (20) @(posedge mclk);
        chk(mode === PMC_DEEPSLEEP);
        fire(1);
        wait_mode(PMC_ACTIVE);
        repeat (12) @(posedge mclk); // rtc pulse must be gone before deep sleep again
        req(PMC_DEEPSLEEP);
        wait_mode(PMC_DEEPSLEEP);
        fire(2);
        wait_mode(PMC_FULLON);
        repeat (12) @(posedge mclk); // reset pulse must be gone before hibernate
        req(PMC_HIBERNATE);
        wait_mode(PMC_HIBERNATE);
        chk(coreSupplyOn === 1'b0 && pllEnabled === 1'b0);
        fire(2);
        wait_mode(PMC_FULLON);
        repeat (2) @(posedge mclk); // let the boot counter see the pulse
        chk(boots == 1 && coreSupplyOn === 1'b1);
        finish_test;
    end
endmodule
